// ===== src/adc_config_and_result_format.sv
// Converter control and result formatting for a 10-bit successive approximation
// converter. Assumes one 20 MHz clock; the analog comparator sits outside.
// Operation
// - Positive reference bits 3-2: 00 supply, 01 external pin, 10 fixed, 11 reserved.
// - Negative reference bits 1-0: 00 ground, 01 external pin, others reserved.
// - Unimplemented configuration bits read zero and ignore writes.
// - Timing register bit 7 chooses right (1) or left (0) justified result.
// - Acquisition bits 5-3 give 0,2,4,6,8,12,16,20 conversion clock periods.
// - Holding capacitor stays connected from start until conversion begins.
// - Clock bits 2-0 select divided system clock or internal RC clock.
// - With RC clock, wait one extra instruction cycle before converting.
// - Left format: bits 9:2 in high, bits 1:0 in low bits 7-6.
// - Right format: bits 9:8 in high bits 1-0, bits 7:0 in low.
// - Holding capacitor discharged after every conversion.
// - On completion clear start bit, set irq flag, load result.
// - Wait two conversion clock periods after complete or an abort during conversion.
`timescale 1ns/10ps
module adc_config_and_result_format
  import adc_ctrl_pkg::*;
(
  input  wire logic       clk_sys,        // System clock, 20 MHz
  input  wire logic       resetn,         // Async reset, active low
  input  wire logic [3:0] reg_addr,       // Register address
  input  wire logic [7:0] reg_wdata,      // Write data
  input  wire logic       reg_write,      // Write strobe
  input  wire logic       reg_read,       // Read strobe
  output logic      [7:0] reg_rdata,      // Read data, cycle after strobe
  input  wire logic       compare_in,     // Comparator result for current trial bit
  output logic      [1:0] pos_ref_sel,    // Positive reference select
  output logic      [1:0] neg_ref_sel,    // Negative reference select
  output logic            hold_connect,   // Holding capacitor to channel
  output logic            hold_discharge, // Holding capacitor discharge
  output logic      [9:0] dac_trial,      // Successive approximation trial code
  output logic            irq             // Level interrupt
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]  ref_reg;
  logic [7:0]  timing_reg;
  logic        enable_reg;
  logic        start_reg;
  logic [9:0]  result_reg;
  logic [9:0]  sar_reg;
  logic [3:0]  bit_idx_reg;
  logic [4:0]  acq_cnt_reg;
  logic [1:0]  rc_wait_reg;
  logic [1:0]  rec_cnt_reg;
  logic        status_reg;
  logic        mask_reg;
  conv_state_t state_reg;

  logic        wr_ctrl;
  logic        start_req;
  logic        abort_req;
  logic        done_event;
  logic        tick;
  logic        use_rc;
  logic [4:0]  acq_len;
  logic [7:0]  high_view;
  logic [7:0]  low_view;
  logic        tick_run;

  assign wr_ctrl   = reg_write && (reg_addr == OFF_CONTROL);
  // Start is only taken from idle; a start during recovery is refused and never latched
  assign start_req = wr_ctrl && reg_wdata[CTRL_START_BIT] && reg_wdata[CTRL_ENABLE_BIT] && !start_reg
                  && (state_reg == ST_IDLE);
  assign abort_req = wr_ctrl && start_reg && (!reg_wdata[CTRL_START_BIT] || !reg_wdata[CTRL_ENABLE_BIT]);
  assign use_rc    = (timing_reg[CLKSEL_LSB +: 3] == CLKSEL_RC_A)
                  || (timing_reg[CLKSEL_LSB +: 3] == CLKSEL_RC_B);
  assign acq_len   = acq_periods(timing_reg[ACQ_LSB +: 3]);
  // Abort restarts the period counter so recovery spans two full periods
  assign tick_run  = ((state_reg == ST_ACQUIRE) || (state_reg == ST_CONVERT) || (state_reg == ST_RECOVER))
                  && !(state_reg == ST_CONVERT && abort_req);
  assign done_event = (state_reg == ST_CONVERT) && tick && (bit_idx_reg == 4'h0);

  conv_clock_gen u_clk (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .run         (tick_run),
    .clk_sel     (timing_reg[CLKSEL_LSB +: 3]),
    .period_tick (tick)
  );

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ref_reg    <= RESET_BYTE;
      timing_reg <= RESET_BYTE;
      mask_reg   <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == OFF_REF_SELECT) begin
        ref_reg <= reg_wdata & REF_SELECT_MASK;
      end else if (reg_addr == OFF_TIMING_FMT) begin
        timing_reg <= reg_wdata & TIMING_FMT_MASK;
      end else if (reg_addr == OFF_IRQ_MASK) begin
        mask_reg <= reg_wdata[IRQ_DONE_BIT];
      end
    end
  end

  // Reserved reference codes fall back to the rails so no pin floats
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pos_ref_sel <= PREF_SUPPLY;
      neg_ref_sel <= NREF_GROUND;
    end else begin
      if (ref_reg[POS_REF_LSB +: 2] == PREF_EXT_PIN || ref_reg[POS_REF_LSB +: 2] == PREF_FIXED) begin
        pos_ref_sel <= ref_reg[POS_REF_LSB +: 2];
      end else begin
        pos_ref_sel <= PREF_SUPPLY;
      end
      if (ref_reg[NEG_REF_LSB +: 2] == NREF_EXT_PIN) begin
        neg_ref_sel <= NREF_EXT_PIN;
      end else begin
        neg_ref_sel <= NREF_GROUND;
      end
    end
  end

  // ****************************************************************
  // Enable and start/done
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      enable_reg <= 1'b0;
    end else if (wr_ctrl) begin
      enable_reg <= reg_wdata[CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      start_reg <= 1'b0;
    end else if (done_event) begin
      start_reg <= 1'b0;
    end else if (start_req) begin
      start_reg <= 1'b1;
    end else if (abort_req) begin
      start_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg   <= ST_IDLE;
      acq_cnt_reg <= 5'h00;
      rc_wait_reg <= 2'h0;
      rec_cnt_reg <= 2'h0;
      bit_idx_reg <= 4'h0;
      sar_reg     <= RESULT_RESET;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          acq_cnt_reg <= 5'h00;
          if (start_req) begin
            rc_wait_reg <= 2'h0;
            // First trial code goes out early so the comparator settles before the first decision
            bit_idx_reg <= 4'(CONV_BITS - 1);
            sar_reg     <= 10'h200;
            state_reg   <= use_rc ? ST_RC_WAIT : ST_ACQUIRE;
          end
        end
        ST_RC_WAIT: begin
          // One instruction cycle lets a sleep instruction go first
          rc_wait_reg <= rc_wait_reg + 2'h1;
          if (abort_req) begin
            state_reg <= ST_IDLE;
          end else if (rc_wait_reg == 2'(INSTR_CYCLE_CLKS - 1)) begin
            state_reg <= ST_ACQUIRE;
          end
        end
        ST_ACQUIRE: begin
          if (abort_req) begin
            state_reg <= ST_IDLE;
          end else if (acq_cnt_reg >= acq_len) begin
            state_reg   <= ST_CONVERT;
          end else if (tick) begin
            acq_cnt_reg <= acq_cnt_reg + 5'h01;
          end
        end
        ST_CONVERT: begin
          if (abort_req) begin
            // Unconverted bits copy the last decided bit
            sar_reg     <= compare_in ? (sar_reg | ((10'h001 << bit_idx_reg) - 10'h001))
                                      : (sar_reg & ~((10'h002 << bit_idx_reg) - 10'h001));
            rec_cnt_reg <= 2'h0;
            state_reg   <= ST_RECOVER;
          end else if (tick) begin
            if (!compare_in) begin
              sar_reg[bit_idx_reg] <= 1'b0;
            end
            if (bit_idx_reg == 4'h0) begin
              rec_cnt_reg <= 2'h0;
              state_reg   <= ST_RECOVER;
            end else begin
              sar_reg[bit_idx_reg - 4'h1] <= 1'b1;
              bit_idx_reg <= bit_idx_reg - 4'h1;
            end
          end
        end
        ST_RECOVER: begin
          if (tick) begin
            rec_cnt_reg <= rec_cnt_reg + 2'h1;
            if (rec_cnt_reg == 2'(POST_CONV_WAIT - 1)) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Result, analog controls, interrupt
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      result_reg <= RESULT_RESET;
    end else if (done_event) begin
      result_reg <= {sar_reg[9:1], compare_in};
    end else if (state_reg == ST_CONVERT && abort_req) begin
      result_reg <= compare_in ? (sar_reg | ((10'h001 << bit_idx_reg) - 10'h001))
                               : (sar_reg & ~((10'h002 << bit_idx_reg) - 10'h001));
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hold_connect   <= 1'b0;
      hold_discharge <= 1'b1;
      dac_trial      <= RESULT_RESET;
    end else begin
      hold_connect   <= enable_reg && (state_reg == ST_ACQUIRE || state_reg == ST_RC_WAIT
                                       || (state_reg == ST_IDLE && start_req));
      hold_discharge <= (state_reg == ST_RECOVER);
      dac_trial      <= sar_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_reg <= 1'b0;
    end else if (done_event) begin
      status_reg <= 1'b1;
    end else if (reg_write && reg_addr == OFF_IRQ_STATUS && reg_wdata[IRQ_DONE_BIT]) begin
      status_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= status_reg && mask_reg;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    if (timing_reg[JUSTIFY_BIT]) begin
      high_view = {6'h00, result_reg[9:8]};
      low_view  = result_reg[7:0];
    end else begin
      high_view = result_reg[9:2];
      low_view  = {result_reg[1:0], 6'h00};
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= RESET_BYTE;
    end else if (reg_read) begin
      if (reg_addr == OFF_CONTROL) begin
        reg_rdata <= {6'h00, start_reg, enable_reg};
      end else if (reg_addr == OFF_REF_SELECT) begin
        reg_rdata <= ref_reg;
      end else if (reg_addr == OFF_TIMING_FMT) begin
        reg_rdata <= timing_reg;
      end else if (reg_addr == OFF_RESULT_HIGH) begin
        reg_rdata <= high_view;
      end else if (reg_addr == OFF_RESULT_LOW) begin
        reg_rdata <= low_view;
      end else if (reg_addr == OFF_IRQ_STATUS) begin
        reg_rdata <= {7'h00, status_reg};
      end else if (reg_addr == OFF_IRQ_MASK) begin
        reg_rdata <= {7'h00, mask_reg};
      end else begin
        reg_rdata <= RESET_BYTE;
      end
    end else begin
      reg_rdata <= RESET_BYTE;
    end
  end

endmodule

// ===== src/adc_ctrl_pkg.sv
// Package for the converter control block: register offsets, field layouts,
// reset values, clock divider and acquisition tables, state encoding.
// Assumes a single 20 MHz system clock domain.
package adc_ctrl_pkg;

  // ****************************************************************
  // Register map (byte offsets on the plain register port)
  // ****************************************************************
  localparam logic [3:0] OFF_CONTROL     = 4'h0;
  localparam logic [3:0] OFF_REF_SELECT  = 4'h1;
  localparam logic [3:0] OFF_TIMING_FMT  = 4'h2;
  localparam logic [3:0] OFF_RESULT_HIGH = 4'h3;
  localparam logic [3:0] OFF_RESULT_LOW  = 4'h4;
  localparam logic [3:0] OFF_IRQ_STATUS  = 4'h5;
  localparam logic [3:0] OFF_IRQ_MASK    = 4'h6;
  localparam logic [3:0] OFF_SAMPLE_IN   = 4'h7;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_START_BIT  = 1;
  localparam int POS_REF_LSB     = 2;
  localparam int NEG_REF_LSB     = 0;
  localparam int JUSTIFY_BIT     = 7;
  localparam int ACQ_LSB         = 3;
  localparam int CLKSEL_LSB      = 0;
  localparam int IRQ_DONE_BIT    = 0;

  localparam logic [7:0] REF_SELECT_MASK = 8'h0F;
  localparam logic [7:0] TIMING_FMT_MASK = 8'hBF;
  localparam logic [7:0] CONTROL_MASK    = 8'h03;
  localparam logic [7:0] IRQ_MASK_BITS   = 8'h01;

  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [9:0] RESULT_RESET    = 10'h000;

  // ****************************************************************
  // Reference encodings
  // ****************************************************************
  localparam logic [1:0] PREF_SUPPLY   = 2'h0;
  localparam logic [1:0] PREF_EXT_PIN  = 2'h1;
  localparam logic [1:0] PREF_FIXED    = 2'h2;
  localparam logic [1:0] NREF_GROUND   = 2'h0;
  localparam logic [1:0] NREF_EXT_PIN  = 2'h1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int   SYS_CLK_HZ       = 20_000_000;
  localparam int   RC_CLK_HZ        = 600_000;
  // RC clock modelled as a divided system clock, half period in system cycles
  localparam int   RC_HALF_CYCLES   = SYS_CLK_HZ / (2 * RC_CLK_HZ);
  localparam int   INSTR_CYCLE_CLKS = 4;
  localparam int   CONV_BITS        = 10;
  localparam int   POST_CONV_WAIT   = 2;
  localparam logic [2:0] CLKSEL_RC_A = 3'h3;
  localparam logic [2:0] CLKSEL_RC_B = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RC_WAIT = 3'b001,
    ST_ACQUIRE = 3'b010,
    ST_CONVERT = 3'b011,
    ST_RECOVER = 3'b100
  } conv_state_t;

  // Half periods in system clocks per clock select code (000..111)
  function automatic logic [5:0] half_period(input logic [2:0] sel);
    case (sel)
      3'h0:    half_period = 6'h01;
      3'h1:    half_period = 6'h04;
      3'h2:    half_period = 6'h10;
      3'h4:    half_period = 6'h02;
      3'h5:    half_period = 6'h08;
      3'h6:    half_period = 6'h20;
      default: half_period = 6'(RC_HALF_CYCLES);
    endcase
  endfunction

  // Acquisition length in conversion clock periods
  function automatic logic [4:0] acq_periods(input logic [2:0] code);
    case (code)
      3'h0:    acq_periods = 5'h00;
      3'h1:    acq_periods = 5'h02;
      3'h2:    acq_periods = 5'h04;
      3'h3:    acq_periods = 5'h06;
      3'h4:    acq_periods = 5'h08;
      3'h5:    acq_periods = 5'h0C;
      3'h6:    acq_periods = 5'h10;
      default: acq_periods = 5'h14;
    endcase
  endfunction

endpackage

// ===== src/conv_clock_gen.sv
// Conversion clock tick generator: one pulse per conversion clock period.
// Assumes the selection is stable while a conversion runs.
`timescale 1ns/10ps
module conv_clock_gen
  import adc_ctrl_pkg::*;
(
  input  wire logic       clk_sys,   // System clock
  input  wire logic       resetn,    // Async reset, active low
  input  wire logic       run,       // Counting allowed
  input  wire logic [2:0] clk_sel,   // Conversion clock select
  output logic            period_tick // One pulse per full period
);

  logic [5:0] count_reg;
  logic       phase_reg;
  logic [5:0] half_limit;

  assign half_limit = half_period(clk_sel);

  // Restarts on each run so the first period is a full one
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_reg   <= 6'h00;
      phase_reg   <= 1'b0;
      period_tick <= 1'b0;
    end else if (!run) begin
      count_reg   <= 6'h00;
      phase_reg   <= 1'b0;
      period_tick <= 1'b0;
    end else if (count_reg + 6'h01 >= half_limit) begin
      count_reg   <= 6'h00;
      phase_reg   <= ~phase_reg;
      period_tick <= phase_reg;
    end else begin
      count_reg   <= count_reg + 6'h01;
      period_tick <= 1'b0;
    end
  end

endmodule

// ===== tb/adc_cfg_chk.sv
// Port-level checker for the converter control block.
// Assumes it is bound to the top module and that the clock select stays put during a conversion.
`timescale 1ns/10ps
module adc_cfg_chk
  import adc_ctrl_pkg::*;
(
  input wire logic       clk_sys,        // System clock
  input wire logic       resetn,         // Async reset, active low
  input wire logic [3:0] reg_addr,       // Register address
  input wire logic [7:0] reg_wdata,      // Write data
  input wire logic       reg_write,      // Write strobe
  input wire logic       reg_read,       // Read strobe
  input wire logic [7:0] reg_rdata,      // Read data
  input wire logic [1:0] pos_ref_sel,    // Positive reference select
  input wire logic [1:0] neg_ref_sel,    // Negative reference select
  input wire logic       hold_connect,   // Capacitor connected
  input wire logic       hold_discharge, // Capacitor discharge
  input wire logic       irq             // Level interrupt
);
  // ****************************************************************
  // Helper state
  // ****************************************************************
  logic [7:0]  tmg_reg;
  logic [11:0] hc_cnt;
  logic [11:0] cv_cnt;
  logic [11:0] rec_cnt;
  logic        ab_reg;
  int          per;
  int          acq;

  // Windows are a little wide because the tick phase at start is not fixed
  assign per = (tmg_reg[1:0] == 2'h3) ? 32 : ((tmg_reg[2] ? 4 : 2) << (2 * tmg_reg[1:0]));
  assign acq = (tmg_reg[5:3] < 3'h5) ? 2 * tmg_reg[5:3] : 4 * tmg_reg[5:3] - 8;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tmg_reg <= 8'h00;
    end else if (reg_write && reg_addr == OFF_TIMING_FMT) begin
      tmg_reg <= reg_wdata;
    end
  end

  // Marks a conversion cut short by a control write, so its discharge is not timed as a completion
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ab_reg <= 1'b0;
    end else if (reg_write && reg_addr == OFF_CONTROL && reg_wdata[1:0] != 2'h3) begin
      ab_reg <= 1'b1;
    end else if ($fell(hold_connect)) begin
      ab_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hc_cnt  <= 12'h000;
      cv_cnt  <= 12'h000;
      rec_cnt <= 12'h000;
    end else begin
      hc_cnt  <= hold_connect ? hc_cnt + 12'h001 : 12'h000;
      cv_cnt  <= $fell(hold_connect) ? 12'h001 : (cv_cnt != 12'h000 && !hold_discharge) ? cv_cnt + 12'h001 : 12'h000;
      rec_cnt <= !hold_discharge ? 12'h000 : ($rose(hold_discharge) || rec_cnt != 12'h000) ? rec_cnt + 12'h001 : 12'h000;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_ref_wr;
    reg_write && reg_addr == OFF_REF_SELECT;
  endsequence
  sequence s_conv_done;
    $rose(hold_discharge) ##0 cv_cnt != 12'h000 ##0 !ab_reg;
  endsequence

  a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside its slot");
  a_pref_legal: assert property (pos_ref_sel != 2'h3)
    else $error("positive reference on reserved code");
  a_nref_legal: assert property (!neg_ref_sel[1])
    else $error("negative reference on reserved code");
  a_pref_follow: assert property (s_ref_wr ##0 reg_wdata[3:2] != 2'h3 |-> ##2 pos_ref_sel == $past(reg_wdata[3:2], 2))
    else $error("positive reference does not follow write");
  a_nref_follow: assert property (s_ref_wr ##0 !reg_wdata[1] |-> ##2 neg_ref_sel == $past(reg_wdata[1:0], 2))
    else $error("negative reference does not follow write");
  a_hold_exclusive: assert property (!(hold_connect && hold_discharge))
    else $error("capacitor connected while discharging");
  a_acq_length: assert property ($fell(hold_connect) |-> int'(hc_cnt) >= acq * per - 2 && int'(hc_cnt) <= acq * per + per + 8)
    else $error("acquisition length wrong");
  a_conv_discharge: assert property (s_conv_done |-> int'(cv_cnt) >= 10 * per - 2 && int'(cv_cnt) <= 11 * per + 4)
    else $error("discharge not after ten conversion periods");
  a_recover_len: assert property ($fell(hold_discharge) && rec_cnt != 12'h000 |-> int'(rec_cnt) >= 2 * per - 2 && int'(rec_cnt) <= 2 * per + 4)
    else $error("recovery wait not two periods");
  a_irq_cause: assert property ($rose(irq) |-> $rose(hold_discharge) || $past(reg_write, 2))
    else $error("interrupt rose without completion or mask write");
endmodule

// ===== tb/adc_config_and_result_format_tb_top.sv
// Self-checking bench for the converter control block: registers, references, timing, result layout.
// Assumes the comparator is a compare of a target code against the trial code.
`timescale 1ns/10ps
module adc_config_and_result_format_tb_top
  import adc_ctrl_pkg::*;
();
  logic        clk_sys;
  logic        resetn;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [7:0]  reg_rdata;
  logic        compare_in;
  logic [1:0]  pos_ref_sel;
  logic [1:0]  neg_ref_sel;
  logic        hold_connect;
  logic        hold_discharge;
  logic [9:0]  dac_trial;
  logic        irq;
  logic [31:0] rng;
  logic [9:0]  target;
  int          n_mismatch;
  int          tests_run;

  adc_config_and_result_format u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .compare_in(compare_in),
    .pos_ref_sel(pos_ref_sel), .neg_ref_sel(neg_ref_sel), .hold_connect(hold_connect),
    .hold_discharge(hold_discharge), .dac_trial(dac_trial), .irq(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Comparator settles within a cycle of the trial code; above when the target reaches it
  assign compare_in = (target >= dac_trial);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // {high, low}; reserved bits of each view are masked off before comparing
  function automatic logic [15:0] layout(input logic [9:0] t, input logic just);
    return just ? {6'h00, t} : {t, 6'h00};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic convert(input logic [2:0] clk_code, input logic [2:0] acq_code, input logic mask);
    logic [7:0] d;
    logic [7:0] hi;
    logic [7:0] lo;
    logic       just;
    int         n;
    rng    = xorshift(rng);
    target = rng[9:0];
    just   = rng[12];
    wr(OFF_TIMING_FMT, {just, rng[13], acq_code, clk_code});
    wr(OFF_IRQ_MASK, {7'h00, mask});
    wr(OFF_CONTROL, 8'h03);
    n = 0;
    d = 8'h02;
    while (d[CTRL_START_BIT] && n < 2000) begin
      rd(OFF_CONTROL, d);
      n++;
    end
    chk(16'(n < 2000), 16'h0001);
    @(negedge clk_sys);
    chk(16'(irq), 16'(mask));
    chk(16'(dac_trial), 16'(target));
    rd(OFF_IRQ_STATUS, d);
    chk(16'(d[0]), 16'h0001);
    rd(OFF_RESULT_HIGH, hi);
    rd(OFF_RESULT_LOW, lo);
    chk({hi, lo} & layout(10'h3FF, just), layout(target, just));
    wr(OFF_TIMING_FMT, {~just, 1'b0, acq_code, clk_code});
    rd(OFF_RESULT_HIGH, hi);
    rd(OFF_RESULT_LOW, lo);
    chk({hi, lo} & layout(10'h3FF, ~just), layout(target, ~just));
    if (!mask) begin
      wr(OFF_IRQ_MASK, 8'h01);
      repeat (2) @(negedge clk_sys);
      chk(16'(irq), 16'h0001);
    end
    wr(OFF_IRQ_STATUS, 8'h01);
    repeat (2) @(negedge clk_sys);
    chk(16'(irq), 16'h0000);
    // Recovery of two periods must pass before the next start is accepted
    repeat (140) @(posedge clk_sys);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [7:0] d;
    logic [7:0] e;
    resetn     = 1'b0;
    reg_addr   = 4'h0;
    reg_wdata  = 8'h00;
    reg_write  = 1'b0;
    reg_read   = 1'b0;
    target     = 10'h000;
    rng        = 32'hBB037A2D;
    n_mismatch = 0;
    tests_run  = 0;
    repeat (4) @(posedge clk_sys);
    chk(16'(hold_discharge), 16'h0001);
    resetn <= 1'b1;
    for (int a = 0; a < 7; a++) begin
      rd(4'(a), d);
      chk(16'(d), 16'h0000);
    end
    wr(4'hF, 8'hFF);
    rd(4'hF, d);
    chk(16'(d), 16'h0000);
    for (int i = 0; i < 24; i++) begin
      rng = xorshift(rng);
      d   = (i < 16) ? {rng[7:4], 4'(i)} : rng[7:0];
      wr(OFF_REF_SELECT, d);
      repeat (2) @(negedge clk_sys);
      chk(16'(pos_ref_sel), (d[3:2] == 2'h3) ? 16'h0000 : 16'(d[3:2]));
      chk(16'(neg_ref_sel), d[1] ? 16'h0000 : 16'(d[1:0]));
      rd(OFF_REF_SELECT, e);
      chk(16'(e), 16'(d[3:0]));
      wr(OFF_TIMING_FMT, rng[15:8]);
      rd(OFF_TIMING_FMT, e);
      chk(16'(e), 16'(rng[15:8] & 8'hBF));
    end
    for (int i = 0; i < 8; i++) convert(3'(i), 3'(7 - i), i != 3);
    // Abort mid conversion, then a start inside the recovery wait must be refused
    wr(OFF_TIMING_FMT, 8'h06);
    wr(OFF_CONTROL, 8'h03);
    repeat (100) @(posedge clk_sys);
    wr(OFF_CONTROL, 8'h01);
    rd(OFF_CONTROL, d);
    chk(16'(d), 16'h0001);
    chk(16'(hold_discharge), 16'h0001);
    wr(OFF_CONTROL, 8'h03);
    rd(OFF_CONTROL, d);
    chk(16'(d), 16'h0001);
    rd(OFF_IRQ_STATUS, d);
    chk(16'(d), 16'h0000);
    repeat (200) @(posedge clk_sys);
    chk(16'(hold_discharge), 16'h0000);
    results();
  end

  initial begin
    #(60000 * 50);
    n_mismatch++;
    $display("ERROR at %0t: run did not finish", $time);
    results();
  end
endmodule

bind adc_config_and_result_format adc_cfg_chk u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .pos_ref_sel(pos_ref_sel), .neg_ref_sel(neg_ref_sel),
  .hold_connect(hold_connect), .hold_discharge(hold_discharge), .irq(irq)
);
